// [src/cpm_prog_model.v]
// processor programming model: accumulators, index, stack pointer,
// instruction pointer and condition flags, with a one-instruction executor.
// assumes an Avalon-MM master on ref_clk_i and an asynchronous irq pin.
`timescale 1ns/1ps
`include "cpm_defines.vh"
module cpm_prog_model (
   // clock and reset
   input  wire        ref_clk_i,
   input  wire        rst_i,
   // avalon-mm slave
   input  wire [5:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   input  wire [3:0]  avs_byteenable_i,
   output reg  [31:0] avs_readdata_o,
   output reg         avs_waitrequest_o,
   // system side
   input  wire        irq_i,
   output reg         irq_accept_o,
   output reg  [15:0] fetch_addr_o,
   output reg         test_count_o
);
   // architectural state
   reg  [7:0]  first_accumulator;
   reg  [7:0]  second_accumulator;
   reg  [15:0] index_pointer;
   reg  [15:0] stack_pointer;
   reg  [15:0] instruction_pointer;
   reg  [5:0]  condition_flags;
   reg  [15:0] operand;
   reg         test_mode;
   // next values
   reg  [7:0]  next_first;
   reg  [7:0]  next_second;
   reg  [15:0] next_index;
   reg  [15:0] next_stack;
   reg  [15:0] next_ip;
   reg  [5:0]  next_flags;
   reg  [15:0] next_operand;
   reg         next_test;
   // bus helpers
   reg  [31:0] read_mux;
   reg         irq_meta;
   reg         irq_sync;
   wire        bus_ack;
   wire        wr_go;
   wire        exec_go;
   wire [7:0]  op;
   wire [15:0] wd16;
   wire [15:0] double_acc;
   // alu
   wire [7:0]  alu_b;
   wire        alu_sub;
   wire [7:0]  alu_sum;
   wire        alu_half;
   wire        alu_carry;
   wire        alu_ovf;
   // double-width arithmetic and branch decision
   wire [16:0] addd_sum;
   wire [15:0] asld_val;
   wire [15:0] branch_ip;
   reg         cond_true;
   wire        branch_taken;

   assign bus_ack = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
   assign wr_go   = avs_write_i & ~avs_waitrequest_o;
   assign op      = avs_writedata_i[7:0];
   // test mode locks out further instructions
   assign exec_go = wr_go && (avs_address_i == `CPM_OFS_OPCODE) && avs_byteenable_i[0] && !test_mode;
   assign wd16    = {avs_byteenable_i[1] ? avs_writedata_i[15:8] : 8'h00,
                     avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00};

   // first accumulator is the high byte
   assign double_acc = {first_accumulator, second_accumulator};

   assign alu_b   = (op == `CPM_OP_INCA || op == `CPM_OP_DECA) ? 8'h01 : second_accumulator;
   assign alu_sub = (op == `CPM_OP_SBA || op == `CPM_OP_DECA);

   cpm_alu8 u_alu (
      .a_i     (first_accumulator),
      .b_i     (alu_b),
      .sub_i   (alu_sub),
      .cin_i   (1'b0),
      .sum_o   (alu_sum),
      .half_o  (alu_half),
      .carry_o (alu_carry),
      .ovf_o   (alu_ovf)
   );

   assign addd_sum = {1'b0, double_acc} + {1'b0, operand};
   assign asld_val = {double_acc[14:0], 1'b0};
   // branch offset is signed, relative to the following instruction
   assign branch_ip = instruction_pointer + 16'h0002 + {{8{operand[7]}}, operand[7:0]};

   always @* begin
      case (op[3:1])
         3'h0: cond_true = 1'b0;
         3'h1: cond_true = condition_flags[`CPM_FLG_C] | condition_flags[`CPM_FLG_Z];
         3'h2: cond_true = condition_flags[`CPM_FLG_C];
         3'h3: cond_true = condition_flags[`CPM_FLG_Z];
         3'h4: cond_true = condition_flags[`CPM_FLG_V];
         3'h5: cond_true = condition_flags[`CPM_FLG_N];
         3'h6: cond_true = condition_flags[`CPM_FLG_N] ^ condition_flags[`CPM_FLG_V];
         3'h7: cond_true = condition_flags[`CPM_FLG_Z] |
                           (condition_flags[`CPM_FLG_N] ^ condition_flags[`CPM_FLG_V]);
         default: cond_true = 1'b0;
      endcase
   end
   // odd codes take the condition, even codes its complement
   assign branch_taken = op[0] ? cond_true : ~cond_true;

   // register read mux
   always @* begin
      case (avs_address_i)
         `CPM_OFS_ACC_FIRST:  read_mux = {24'h000000, first_accumulator};
         `CPM_OFS_ACC_SECOND: read_mux = {24'h000000, second_accumulator};
         `CPM_OFS_ACC_DOUBLE: read_mux = {16'h0000, double_acc};
         `CPM_OFS_INDEX:      read_mux = {16'h0000, index_pointer};
         `CPM_OFS_STACK:      read_mux = {16'h0000, stack_pointer};
         `CPM_OFS_IP:         read_mux = {16'h0000, instruction_pointer};
         // top two flag bits read as one
         `CPM_OFS_FLAGS:      read_mux = {24'h000000, `CPM_FLAGS_TOP, condition_flags};
         `CPM_OFS_OPERAND:    read_mux = {16'h0000, operand};
         `CPM_OFS_STATUS:     read_mux = {30'h0, irq_accept_o, test_mode};
         default:             read_mux = 32'h00000000;
      endcase
   end

   // next-state: bus writes and instruction execution
   always @* begin
      next_first   = first_accumulator;
      next_second  = second_accumulator;
      next_index   = index_pointer;
      next_stack   = stack_pointer;
      next_ip      = instruction_pointer;
      next_flags   = condition_flags;
      next_operand = operand;
      next_test    = test_mode;
      if (test_mode) begin
         next_ip = instruction_pointer + 16'h0001;
      end else if (exec_go) begin
         // advance past a one-byte instruction by default
         next_ip = instruction_pointer + 16'h0001;
         if (op[7:4] == `CPM_BRANCH_HI) begin
            next_ip = branch_taken ? branch_ip : instruction_pointer + 16'h0002;
         end else begin
            case (op)
               `CPM_OP_ABA, `CPM_OP_SBA, `CPM_OP_INCA, `CPM_OP_DECA: begin
                  // ALU result back to the first accumulator
                  next_first = alu_sum;
                  next_flags[`CPM_FLG_N] = alu_sum[7];
                  next_flags[`CPM_FLG_Z] = (alu_sum == 8'h00);
                  next_flags[`CPM_FLG_V] = alu_ovf;
                  if (op == `CPM_OP_ABA || op == `CPM_OP_SBA)
                     next_flags[`CPM_FLG_C] = alu_carry;
                  if (op == `CPM_OP_ABA)
                     next_flags[`CPM_FLG_H] = alu_half;
               end
               `CPM_OP_CLRA, `CPM_OP_CLRB: begin
                  if (op == `CPM_OP_CLRA)
                     next_first = 8'h00;
                  else
                     next_second = 8'h00;
                  next_flags[`CPM_FLG_N] = 1'b0;
                  next_flags[`CPM_FLG_Z] = 1'b1;
                  next_flags[`CPM_FLG_V] = 1'b0;
                  next_flags[`CPM_FLG_C] = 1'b0;
               end
               `CPM_OP_ADDD: begin
                  // double result lands in both accumulators
                  {next_first, next_second} = addd_sum[15:0];
                  next_flags[`CPM_FLG_N] = addd_sum[15];
                  next_flags[`CPM_FLG_Z] = (addd_sum[15:0] == 16'h0000);
                  next_flags[`CPM_FLG_V] = (double_acc[15] == operand[15]) &&
                                           (addd_sum[15] != double_acc[15]);
                  next_flags[`CPM_FLG_C] = addd_sum[16];
                  next_ip = instruction_pointer + 16'h0003;
               end
               `CPM_OP_ASLD: begin
                  {next_first, next_second} = asld_val;
                  next_flags[`CPM_FLG_N] = asld_val[15];
                  next_flags[`CPM_FLG_Z] = (asld_val == 16'h0000);
                  next_flags[`CPM_FLG_C] = double_acc[15];
                  next_flags[`CPM_FLG_V] = asld_val[15] ^ double_acc[15];
               end
               `CPM_OP_INX: begin
                  next_index = index_pointer + 16'h0001;
                  next_flags[`CPM_FLG_Z] = (next_index == 16'h0000);
               end
               `CPM_OP_DEX: begin
                  next_index = index_pointer - 16'h0001;
                  next_flags[`CPM_FLG_Z] = (next_index == 16'h0000);
               end
               `CPM_OP_ABX: next_index = index_pointer + {8'h00, second_accumulator};
               // stack pointer moves to the next free slot
               `CPM_OP_INS: next_stack = stack_pointer + 16'h0001;
               `CPM_OP_DES: next_stack = stack_pointer - 16'h0001;
               `CPM_OP_TSX: next_index = stack_pointer + 16'h0001;
               `CPM_OP_TXS: next_stack = index_pointer - 16'h0001;
               `CPM_OP_TAP: next_flags = first_accumulator[5:0];
               `CPM_OP_TPA: next_first = {`CPM_FLAGS_TOP, condition_flags};
               `CPM_OP_CLC: next_flags[`CPM_FLG_C] = 1'b0;
               `CPM_OP_SEC: next_flags[`CPM_FLG_C] = 1'b1;
               `CPM_OP_CLI: next_flags[`CPM_FLG_I] = 1'b0;
               `CPM_OP_SEI: next_flags[`CPM_FLG_I] = 1'b1;
               `CPM_OP_TEST_A, `CPM_OP_TEST_B: next_test = 1'b1;
               // unassigned codes only step past themselves
               default: next_ip = instruction_pointer + 16'h0001;
            endcase
         end
      end else if (wr_go) begin
         case (avs_address_i)
            `CPM_OFS_ACC_FIRST: begin
               if (avs_byteenable_i[0])
                  next_first = avs_writedata_i[7:0];
            end
            `CPM_OFS_ACC_SECOND: begin
               if (avs_byteenable_i[0])
                  next_second = avs_writedata_i[7:0];
            end
            `CPM_OFS_ACC_DOUBLE: begin
               if (avs_byteenable_i[1])
                  next_first = avs_writedata_i[15:8];
               if (avs_byteenable_i[0])
                  next_second = avs_writedata_i[7:0];
            end
            `CPM_OFS_INDEX:   next_index   = (index_pointer & ~be_mask(avs_byteenable_i)) | wd16;
            `CPM_OFS_STACK:   next_stack   = (stack_pointer & ~be_mask(avs_byteenable_i)) | wd16;
            `CPM_OFS_IP:      next_ip      = (instruction_pointer & ~be_mask(avs_byteenable_i)) | wd16;
            `CPM_OFS_OPERAND: next_operand = (operand & ~be_mask(avs_byteenable_i)) | wd16;
            `CPM_OFS_FLAGS: begin
               if (avs_byteenable_i[0])
                  next_flags = avs_writedata_i[5:0];
            end
            default: next_flags = condition_flags;
         endcase
      end
   end

   // byte-lane mask for 16-bit registers
   function [15:0] be_mask;
      input [3:0] be;
      begin
         be_mask = {{8{be[1]}}, {8{be[0]}}};
      end
   endfunction

   // slave handshake: one wait cycle, then answer for one cycle
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h00000000;
      end else begin
         if ((avs_read_i | avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= avs_read_i ? read_mux : 32'h00000000;
         end else begin
            avs_waitrequest_o <= 1'b1;
         end
      end
   end

   // architectural registers
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         first_accumulator   <= `CPM_RST_BYTE;
         second_accumulator  <= `CPM_RST_BYTE;
         index_pointer       <= `CPM_RST_WORD;
         stack_pointer       <= `CPM_RST_WORD;
         instruction_pointer <= `CPM_RST_WORD;
         condition_flags     <= `CPM_RST_FLAGS;
         operand             <= `CPM_RST_WORD;
         test_mode           <= 1'b0;
         fetch_addr_o        <= `CPM_RST_WORD;
         test_count_o        <= 1'b0;
      end else begin
         first_accumulator   <= next_first;
         second_accumulator  <= next_second;
         index_pointer       <= next_index;
         stack_pointer       <= next_stack;
         instruction_pointer <= next_ip;
         condition_flags     <= next_flags;
         operand             <= next_operand;
         test_mode           <= next_test;
         // address lines follow the instruction pointer
         fetch_addr_o        <= next_ip;
         test_count_o        <= next_test;
      end
   end

   // irq pin synchroniser and masked acceptance
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_meta     <= 1'b0;
         irq_sync     <= 1'b0;
         irq_accept_o <= 1'b0;
      end else begin
         irq_meta     <= irq_i;
         irq_sync     <= irq_meta;
         irq_accept_o <= irq_sync & ~condition_flags[`CPM_FLG_I];
      end
   end
endmodule // cpm_prog_model

// [src/cpm_defines.vh]
// constants for the programming-model block: register map, reset values,
// flag positions and decoded opcodes; included by cpm_prog_model, its checker and the bench
`ifndef CPM_DEFINES_VH
`define CPM_DEFINES_VH

// register byte offsets on the slave bus
`define CPM_OFS_ACC_FIRST  6'h00
`define CPM_OFS_ACC_SECOND 6'h04
`define CPM_OFS_ACC_DOUBLE 6'h08
`define CPM_OFS_INDEX      6'h0c
`define CPM_OFS_STACK      6'h10
`define CPM_OFS_IP         6'h14
`define CPM_OFS_FLAGS      6'h18
`define CPM_OFS_OPCODE     6'h1c
`define CPM_OFS_OPERAND    6'h20
`define CPM_OFS_STATUS     6'h24

// reset values
`define CPM_RST_BYTE       8'h00
`define CPM_RST_WORD       16'h0000
`define CPM_RST_FLAGS      6'h10

// condition flag positions
`define CPM_FLG_C          0
`define CPM_FLG_V          1
`define CPM_FLG_Z          2
`define CPM_FLG_N          3
`define CPM_FLG_I          4
`define CPM_FLG_H          5
`define CPM_FLAGS_TOP      2'h3

// decoded opcodes
`define CPM_OP_NOP         8'h01
`define CPM_OP_ASLD        8'h05
`define CPM_OP_TAP         8'h06
`define CPM_OP_TPA         8'h07
`define CPM_OP_INX         8'h08
`define CPM_OP_DEX         8'h09
`define CPM_OP_CLC         8'h0c
`define CPM_OP_SEC         8'h0d
`define CPM_OP_CLI         8'h0e
`define CPM_OP_SEI         8'h0f
`define CPM_OP_SBA         8'h10
`define CPM_OP_ABA         8'h1b
`define CPM_OP_TSX         8'h30
`define CPM_OP_INS         8'h31
`define CPM_OP_DES         8'h34
`define CPM_OP_TXS         8'h35
`define CPM_OP_ABX         8'h3a
`define CPM_OP_DECA        8'h4a
`define CPM_OP_INCA        8'h4c
`define CPM_OP_TEST_A      8'h4e
`define CPM_OP_CLRA        8'h4f
`define CPM_OP_TEST_B      8'h5e
`define CPM_OP_CLRB        8'h5f
`define CPM_OP_ADDD        8'hc3
`define CPM_BRANCH_HI      4'h2

`endif

// [src/cpm_alu8.v]
// 8-bit adder/subtractor with half carry, carry/borrow and overflow
// purely combinational; the caller owns every register
`timescale 1ns/1ps
module cpm_alu8 (
   // operands
   input  wire [7:0] a_i,
   input  wire [7:0] b_i,
   input  wire       sub_i,
   input  wire       cin_i,
   // results
   output wire [7:0] sum_o,
   output wire       half_o,
   output wire       carry_o,
   output wire       ovf_o
);
   wire [7:0] b_eff;
   wire       c0;
   wire [4:0] low_sum;
   wire [8:0] full_sum;

   // subtraction as a + ~b + 1, borrow in folded into carry in
   assign b_eff    = sub_i ? ~b_i : b_i;
   assign c0       = sub_i ? ~cin_i : cin_i;
   assign low_sum  = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c0};
   assign full_sum = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, c0};
   assign sum_o    = full_sum[7:0];
   assign half_o   = low_sum[4];
   assign carry_o  = sub_i ? ~full_sum[8] : full_sum[8];
   assign ovf_o    = (a_i[7] == b_eff[7]) && (full_sum[7] != a_i[7]);
endmodule // cpm_alu8

// [tb/cpm_prog_model_sva.sv]
// checker for cpm_prog_model: bus handshake, flag byte, irq cause, test mode
// assumes only the port list of cpm_prog_model
`timescale 1ns/1ps
`include "cpm_defines.vh"
module cpm_prog_model_sva (
   // clock and reset
   input wire        ref_clk_i,
   input wire        rst_i,
   // bus
   input wire [5:0]  avs_address_i,
   input wire        avs_read_i,
   input wire        avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0]  avs_byteenable_i,
   input wire [31:0] avs_readdata_o,
   input wire        avs_waitrequest_o,
   // system
   input wire        irq_i,
   input wire        irq_accept_o,
   input wire [15:0] fetch_addr_o,
   input wire        test_count_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   wire ack    = !avs_waitrequest_o;
   wire wr_ack = avs_write_i && ack;
   chk_wait_once: assert property (ack |=> !ack) else $error("waitrequest low two cycles");
   chk_wait_answer: assert property ((avs_read_i || avs_write_i) && !ack |=> ack)
      else $error("request not answered after one wait");
   chk_flags_top: assert property (
      avs_read_i && ack && avs_address_i == `CPM_OFS_FLAGS |-> avs_readdata_o[7:6] == `CPM_FLAGS_TOP)
      else $error("flag byte top bits not one");
   chk_irq_cause: assert property (irq_accept_o |-> $past(irq_i, 3))
      else $error("irq accepted without request");
   chk_test_sticky: assert property (test_count_o |=> test_count_o)
      else $error("test mode left without reset");
   chk_test_step: assert property (
      test_count_o && $past(test_count_o) |-> fetch_addr_o == $past(fetch_addr_o) + 16'h0001)
      else $error("fetch address not counting");
   chk_ip_hold: assert property (!test_count_o && !wr_ack |=> $stable(fetch_addr_o))
      else $error("fetch address moved between instructions");
   chk_ip_step: assert property (
      wr_ack && avs_address_i == `CPM_OFS_OPCODE && avs_byteenable_i[0] && !test_count_o
      && avs_writedata_i[7:0] == `CPM_OP_NOP |=> fetch_addr_o == $past(fetch_addr_o) + 16'h0001)
      else $error("no-op did not advance fetch address");
   cov_flag_read: cover property (avs_read_i && ack && avs_address_i == `CPM_OFS_FLAGS);
   cov_test_on: cover property ($rose(test_count_o));
   cov_irq_on: cover property ($rose(irq_accept_o));
endmodule // cpm_prog_model_sva
bind cpm_prog_model cpm_prog_model_sva u_sva (.ref_clk_i, .rst_i, .avs_address_i, .avs_read_i,
   .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
   .irq_i, .irq_accept_o, .fetch_addr_o, .test_count_o);

// [tb/cpm_sys_model.sv]
// far-side system model: drives the maskable interrupt line
// assumes the bench asks for the irq level through req_i
`timescale 1ns/1ps
module cpm_sys_model (
   // clock and reset
   input  wire ref_clk_i,
   input  wire rst_i,
   // request and line
   input  wire req_i,
   output reg  irq_o
);
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= req_i;
      end
   end
endmodule // cpm_sys_model

// [tb/testbench.sv]
// self-checking bench for cpm_prog_model over its avalon-mm slave
// assumes cpm_sys_model drives irq_i and the checker is bound in
`timescale 1ns/1ps
`include "cpm_defines.vh"
module testbench;
   reg         ref_clk_i        = 1'b0;
   reg         rst_i            = 1'b1;
   reg  [5:0]  avs_address_i    = 6'h00;
   reg         avs_read_i       = 1'b0;
   reg         avs_write_i      = 1'b0;
   reg  [31:0] avs_writedata_i  = 32'h00000000;
   reg  [3:0]  avs_byteenable_i = 4'hf;
   wire [31:0] avs_readdata_o;
   wire        avs_waitrequest_o;
   wire        irq_i;
   reg         irq_req          = 1'b0;
   wire        irq_accept_o;
   wire [15:0] fetch_addr_o;
   wire        test_count_o;
   integer     err_count = 0;
   integer     cmp_count = 0;
   integer     seed      = 53;
   integer     i;
   reg  [31:0] q;
   reg  [15:0] w, ip;
   reg  [7:0]  d, s;
   always #50 ref_clk_i = ~ref_clk_i;
   cpm_prog_model uut (.ref_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .irq_i, .irq_accept_o, .fetch_addr_o, .test_count_o);
   cpm_sys_model u_sys (.ref_clk_i, .rst_i, .req_i(irq_req), .irq_o(irq_i));
   task check(input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // one bus cycle, entered just after a rising edge
   task xfer(input wr_en, input [5:0] adr, input [31:0] dat);
      integer n;
      begin
         avs_address_i   <= adr;
         avs_writedata_i <= dat;
         avs_read_i      <= !wr_en;
         avs_write_i     <= wr_en;
         n = 0;
         @(posedge ref_clk_i);
         while (avs_waitrequest_o !== 1'b0 && n < 50) begin
            @(posedge ref_clk_i);
            n = n + 1;
         end
         q = avs_readdata_o;
         avs_read_i  <= 1'b0;
         avs_write_i <= 1'b0;
         if (n == 50) begin
            err_count = err_count + 1;
            $display("CHECK FAILED t=%0t no answer", $time);
         end
         @(posedge ref_clk_i);
      end
   endtask
   task wr(input [5:0] adr, input [31:0] dat);
      xfer(1'b1, adr, dat);
   endtask
   task rd(input [5:0] adr, input [31:0] exp);
      begin
         xfer(1'b0, adr, 32'h00000000);
         check(q, exp);
      end
   endtask
   task exec(input [7:0] op);
      wr(`CPM_OFS_OPCODE, {24'h000000, op});
   endtask
   function [31:0] add_flags(input [7:0] x, input [7:0] y);
      reg [8:0] t;
      reg [4:0] h;
      begin
         t = x + y;
         h = x[3:0] + y[3:0];
         add_flags = {24'h000000, 2'h3, h[4], 1'b1, t[7], t[7:0] == 8'h00,
                      x[7] == y[7] && t[7] != x[7], t[8]};
      end
   endfunction
   task tally_and_finish;
      begin
         if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
         end else begin
            $display("RESULT: FAIL");
         end
         $finish;
      end
   endtask
   initial begin
      #5000000;
      err_count = err_count + 1;
      tally_and_finish;
   end
   initial begin
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      rd(`CPM_OFS_FLAGS, 32'h000000d0);
      rd(6'h3c, 32'h00000000);
      wr(6'h3c, 32'h0000ffff);
      for (i = 0; i < 8; i = i + 1) begin
         w  = $random(seed);
         ip = $random(seed);
         d  = $random(seed);
         wr(`CPM_OFS_ACC_FIRST, {24'h000000, w[15:8]});
         wr(`CPM_OFS_ACC_SECOND, {24'h000000, w[7:0]});
         rd(`CPM_OFS_ACC_DOUBLE, {16'h0000, w});
         wr(`CPM_OFS_ACC_DOUBLE, {16'h0000, ~w});
         rd(`CPM_OFS_ACC_FIRST, {24'h000000, ~w[15:8]});
         rd(`CPM_OFS_ACC_SECOND, {24'h000000, ~w[7:0]});
         wr(`CPM_OFS_INDEX, {16'h0000, ip});
         rd(`CPM_OFS_INDEX, {16'h0000, ip});
         wr(`CPM_OFS_STACK, {16'h0000, ~ip});
         rd(`CPM_OFS_STACK, {16'h0000, ~ip});
         wr(`CPM_OFS_IP, {16'h0000, ip});
         exec(`CPM_OP_ABA);
         s = ~w[15:8] + ~w[7:0];
         rd(`CPM_OFS_ACC_FIRST, {24'h000000, s});
         rd(`CPM_OFS_FLAGS, add_flags(~w[15:8], ~w[7:0]));
         rd(`CPM_OFS_IP, {16'h0000, ip + 16'h0001});
         wr(`CPM_OFS_OPERAND, {24'h000000, d});
         exec(i[0] ? `CPM_OP_SEC : `CPM_OP_CLC);
         exec(8'h25);
         rd(`CPM_OFS_IP, {16'h0000, ip + 16'h0004 + (i[0] ? {{8{d[7]}}, d} : 16'h0000)});
         // double add lands in both accumulators
         wr(`CPM_OFS_OPERAND, {16'h0000, ip});
         exec(`CPM_OP_ADDD);
         rd(`CPM_OFS_ACC_DOUBLE, {16'h0000, {s, ~w[7:0]} + ip});
         exec(`CPM_OP_INX);
         rd(`CPM_OFS_INDEX, {16'h0000, ip + 16'h0001});
      end
      irq_req <= 1'b1;
      repeat (5) @(posedge ref_clk_i);
      check(irq_accept_o, 1'b0);
      exec(`CPM_OP_CLI);
      repeat (4) @(posedge ref_clk_i);
      check(irq_accept_o, 1'b1);
      rd(`CPM_OFS_STATUS, 32'h00000002);
      exec(`CPM_OP_SEI);
      repeat (4) @(posedge ref_clk_i);
      check(irq_accept_o, 1'b0);
      irq_req <= 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
         rst_i <= 1'b1;
         repeat (2) @(posedge ref_clk_i);
         rst_i <= 1'b0;
         @(posedge ref_clk_i);
         check(test_count_o, 1'b0);
         exec(`CPM_OP_NOP);
         rd(`CPM_OFS_IP, 32'h00000001);
         wr(`CPM_OFS_IP, 32'h0000fffe);
         exec(i[0] ? `CPM_OP_TEST_B : `CPM_OP_TEST_A);
         check(test_count_o, 1'b1);
         w = fetch_addr_o;
         // wrap at 16 bits before the compare widens it
         w = w + 16'h000a;
         repeat (10) @(posedge ref_clk_i);
         check(fetch_addr_o, w);
         exec(`CPM_OP_NOP);
         check(test_count_o, 1'b1);
      end
      tally_and_finish;
   end
endmodule // testbench
